// ==== logic/i2cp_pkg.sv ====
// Purpose: shared constants and types of the paged register control port
// Assumes: 8-bit registers, two pages of 128, 7-bit bus addressing
// Notes:   all offsets and field positions used by the port live here
package i2cp_pkg;

    // fixed upper bits of the own bus address, low two bits come from pins
    localparam logic [4:0] ADDR_FIXED   = 5'h06;
    localparam logic [7:0] GEN_CALL     = 8'h00;

    // register offsets within a page
    localparam logic [6:0] REG_PAGE     = 7'h00;
    localparam logic [6:0] REG_SRST     = 7'h01;
    localparam logic [6:0] REG_RATE     = 7'h02;
    localparam logic [6:0] REG_DEBUG    = 7'h6b;

    // field positions
    localparam int         PAGE_BIT     = 0;
    localparam int         SRST_BIT     = 7;
    localparam int         RATE_MSB     = 7;
    localparam int         RATE_LSB     = 4;
    localparam int         DBG_STAT_BIT = 0;
    localparam int         DBG_DIS_BIT  = 2;

    // reset values and counts
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic       PAGE0        = 1'b0;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam logic [2:0] FIRST_BIT    = 3'h0;
    // every proper start or stop in a byte state follows one counted rise of scl
    localparam logic [2:0] COND_BIT     = 3'h1;
    localparam logic [6:0] PTR_STEP     = 7'h01;
    localparam int         NUM_ENTRIES  = 256;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_WAIT
    } i2cp_state_t;

endpackage

// ==== logic/i2cp_sync.sv ====
// Purpose: two flip-flop synchroniser for pins arriving from outside
// Assumes: inputs are asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module i2cp_sync #(
    parameter int         WIDTH   = 1,
    parameter logic [3:0] RST_VAL = 4'hf
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] d_out
);

    logic [WIDTH-1:0] meta_q;

    // idle bus lines are high, so reset to high avoids a false start
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_q <= RST_VAL[WIDTH-1:0];
            d_out  <= RST_VAL[WIDTH-1:0];
        end else if (ce) begin
            meta_q <= d_in;
            d_out  <= meta_q;
        end
    end

endmodule

// ==== logic/i2cp_slave_port.sv ====
// Purpose: two-wire slave control port with a paged 8-bit register file
// Assumes: bus lines are oversampled by the 200 MHz clock
// Notes:   sda is open drain; sda_oe high pulls the line low
//
// Contract
// RL1: slave only; never drives scl, transmits only when the master asks.
// RL2: transfers are eight bits, set while scl low, taken on scl high.
// RL3: data changes only with scl low; changes with scl high are conditions.
// RL4: start is sda falling with scl high; stop is sda rising.
// RL5: first byte is 7-bit address plus direction; respond on own address.
// RL6: after each byte addressed to us, pull sda low for ninth clock.
// RL7: master acknowledges each read byte by pulling sda low.
// RL8: sda left high in the acknowledge clock means not-acknowledge.
// RL9: stop idles the bus; start while active is a repeated start.
// RL10: acknowledge the general call address byte of zero.
// RL11: further written bytes go to consecutive registers.
// RL12: master ack during read sends the next consecutive register.
// RL13: bus error detector on after reset; status D0, disable D2, reg 107.
// RL14: two pages of 128 registers; register 0 is page control.
// RL15: addresses 1 to 127 reach the active page until page changes.
// RL16: active page is page 0 after any reset.
// RL17: host should read back page control after writing it.
// RL18: all registers are eight bits, D7 most significant.
// RL19: page control bit D0 selects the page; upper bits written zero.
// RL20: writing one to D7 of register 1 gives a self-clearing soft reset.
// RL21: host should restore driver routing and volume by direct writes.
// RL22: register 2 upper nibble is the ADC rate divisor code, reset zero.
// RL23: own address is fixed 00110 plus the two address select pins.
// RL24: interface select pin tied low for this bus, never changed.
// RL25: first written data byte loads the pointer; reads start there.
`timescale 1ns/1ps
module i2cp_slave_port
    import i2cp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       addr_select_pin0,
    input  wire logic       addr_select_pin1,
    output logic            active_page,
    output logic [3:0]      adc_rate_code,
    output logic            soft_reset_pulse,
    output logic            bus_error_flag,
    output logic            detector_on
);

    logic [3:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        scl_q;
    logic        sda_q;
    logic [6:0]  dev_addr;

    i2cp_sync #(
        .WIDTH   (4),
        .RST_VAL (4'hf)
    ) u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .ce    (ce),
        .d_in  ({addr_select_pin1, addr_select_pin0, sda_i, scl_i}),
        .d_out (pins_s)
    );

    assign scl_s    = pins_s[0];
    assign sda_s    = pins_s[1];
    assign dev_addr = {ADDR_FIXED, pins_s[3], pins_s[2]}; // [RL23]

    // third stage, only used to find edges of the synchronised lines
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    i2cp_state_t state_q;
    logic [2:0]  cnt_q;
    logic        full_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic        sda_oe_q;
    logic        dir_rd_q;
    logic [6:0]  ptr_q;
    logic        ptr_loaded_q;
    logic        mack_q;
    logic        page_q;
    logic        srst_q;
    logic        dbg_dis_q;
    logic        err_q;
    logic [7:0]  mem_q [NUM_ENTRIES];

    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        rx_state;
    logic        byte_state;
    logic        addr_hit;
    logic        gcall;
    logic        page0;

    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_det  = scl_s & scl_q & sda_q & ~sda_s; // [RL4]
    assign stop_det   = scl_s & scl_q & ~sda_q & sda_s; // [RL4]
    assign rx_state   = (state_q == ST_ADDR) || (state_q == ST_WR_BYTE);
    assign byte_state = rx_state || (state_q == ST_RD_BYTE);
    assign addr_hit   = (shift_q[7:1] == dev_addr); // [RL5]
    assign gcall      = (shift_q == GEN_CALL); // [RL10]
    assign page0      = (page_q == PAGE0);

    // write decode: a data byte completes on the fall that opens its ack
    logic        wr_fire;
    logic        wr_reg0;
    logic        wr_srst;
    logic        wr_dbg;
    logic        wr_mem;
    logic [7:0]  wr_idx;

    assign wr_fire = (state_q == ST_WR_BYTE) & scl_fall & full_q
                   & ptr_loaded_q & ~start_det & ~stop_det;
    assign wr_reg0 = wr_fire & (ptr_q == REG_PAGE); // [RL14]
    assign wr_srst = wr_fire & page0 & (ptr_q == REG_SRST)
                   & shift_q[SRST_BIT]; // [RL20]
    assign wr_dbg  = wr_fire & page0 & (ptr_q == REG_DEBUG);
    assign wr_mem  = wr_fire & (ptr_q != REG_PAGE)
                   & ~(page0 & (ptr_q == REG_SRST));
    assign wr_idx  = {page_q, ptr_q}; // [RL15]

    // read decode: first byte from the pointer, later ones from pointer+1
    logic [6:0]  rd_ptr;
    logic [7:0]  rd_mem;
    logic [7:0]  rd_dbg_val;
    logic [7:0]  rd_data;
    logic        rd_load;
    logic        rd_dbg;

    assign rd_ptr     = (state_q == ST_RD_ACK) ? 7'(ptr_q + PTR_STEP)
                                               : ptr_q; // [RL25]
    assign rd_mem     = mem_q[{page_q, rd_ptr}];
    assign rd_dbg_val = {rd_mem[7:DBG_DIS_BIT+1], dbg_dis_q,
                         rd_mem[DBG_DIS_BIT-1:DBG_STAT_BIT+1], err_q};
    assign rd_data    = (rd_ptr == REG_PAGE) ? {7'h00, page_q} :
                        (page0 && rd_ptr == REG_SRST) ? REG_RESET :
                        (page0 && rd_ptr == REG_DEBUG) ? rd_dbg_val :
                        rd_mem; // [RL18]
    assign rd_load    = scl_fall & ~start_det & ~stop_det
                      & (((state_q == ST_ADDR_ACK) & dir_rd_q)
                      | ((state_q == ST_RD_ACK) & mack_q));
    assign rd_dbg     = rd_load & page0 & (rd_ptr == REG_DEBUG);

    // bus error: mid-byte condition; one rise precedes every proper one
    logic        err_set;
    assign err_set = ~dbg_dis_q & (start_det | stop_det) & byte_state
                   & (cnt_q > COND_BIT); // [RL13]

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q      <= ST_IDLE;
            cnt_q        <= FIRST_BIT;
            full_q       <= 1'b0;
            shift_q      <= REG_RESET;
            tx_q         <= REG_RESET;
            sda_oe_q     <= 1'b0;
            dir_rd_q     <= 1'b0;
            ptr_q        <= REG_PAGE;
            ptr_loaded_q <= 1'b0;
            mack_q       <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                // a start also aborts whatever byte was in flight
                state_q      <= ST_ADDR; // [RL9]
                cnt_q        <= FIRST_BIT;
                full_q       <= 1'b0;
                sda_oe_q     <= 1'b0;
                ptr_loaded_q <= 1'b0;
            end else if (stop_det) begin
                state_q  <= ST_IDLE; // [RL9]
                cnt_q    <= FIRST_BIT;
                full_q   <= 1'b0;
                sda_oe_q <= 1'b0;
            end else begin
                if (scl_rise && rx_state) begin
                    shift_q <= {shift_q[6:0], sda_s}; // [RL2]
                end
                if (scl_rise && byte_state) begin
                    cnt_q <= 3'(cnt_q + 3'h1);
                    if (cnt_q == LAST_BIT) begin
                        full_q <= 1'b1;
                    end
                end
                if (scl_rise && state_q == ST_RD_ACK) begin
                    mack_q <= ~sda_s; // [RL7] [RL8]
                end
                // every change of our drive happens just after scl falls
                if (scl_fall) begin // [RL3]
                    unique case (state_q)
                        ST_IDLE, ST_WAIT: begin
                        end
                        ST_ADDR: begin
                            if (full_q) begin
                                full_q <= 1'b0;
                                if (addr_hit || gcall) begin
                                    sda_oe_q <= 1'b1; // [RL6]
                                    dir_rd_q <= shift_q[0] & ~gcall;
                                    state_q  <= ST_ADDR_ACK;
                                end else begin
                                    state_q <= ST_WAIT; // [RL8]
                                end
                            end
                        end
                        ST_ADDR_ACK: begin
                            if (dir_rd_q) begin
                                tx_q     <= rd_data;
                                sda_oe_q <= ~rd_data[7]; // [RL1]
                                state_q  <= ST_RD_BYTE;
                            end else begin
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_WR_BYTE;
                            end
                        end
                        ST_WR_BYTE: begin
                            if (full_q) begin
                                full_q   <= 1'b0;
                                sda_oe_q <= 1'b1; // [RL6]
                                state_q  <= ST_WR_ACK;
                                if (!ptr_loaded_q) begin
                                    ptr_q        <= shift_q[6:0]; // [RL25]
                                    ptr_loaded_q <= 1'b1;
                                end else begin
                                    ptr_q <= 7'(ptr_q + PTR_STEP); // [RL11]
                                end
                            end
                        end
                        ST_WR_ACK: begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_WR_BYTE;
                        end
                        ST_RD_BYTE: begin
                            if (full_q) begin
                                full_q   <= 1'b0;
                                sda_oe_q <= 1'b0;
                                state_q  <= ST_RD_ACK;
                            end else begin
                                tx_q     <= {tx_q[6:0], 1'b0};
                                sda_oe_q <= ~tx_q[6]; // [RL2]
                            end
                        end
                        ST_RD_ACK: begin
                            if (mack_q) begin
                                ptr_q    <= 7'(ptr_q + PTR_STEP); // [RL12]
                                tx_q     <= rd_data;
                                sda_oe_q <= ~rd_data[7];
                                state_q  <= ST_RD_BYTE;
                            end else begin
                                state_q <= ST_WAIT;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // control registers kept outside the plain storage array
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            page_q    <= PAGE0; // [RL16]
            srst_q    <= 1'b0;
            dbg_dis_q <= 1'b0; // [RL13]
            err_q     <= 1'b0;
        end else if (ce) begin
            srst_q <= wr_srst; // [RL20]
            if (srst_q) begin
                page_q    <= PAGE0; // [RL16]
                dbg_dis_q <= 1'b0;
                err_q     <= 1'b0;
            end else begin
                if (wr_reg0) begin
                    page_q <= shift_q[PAGE_BIT]; // [RL19]
                end
                if (wr_dbg) begin
                    dbg_dis_q <= shift_q[DBG_DIS_BIT]; // [RL13]
                end
                // a new error wins over the read that clears the flag
                if (err_set) begin
                    err_q <= 1'b1;
                end else if (rd_dbg) begin
                    err_q <= 1'b0;
                end
            end
        end
    end

    // storage for both pages; entries behind page control and soft reset stay unused
    for (genvar gi = 0; gi < NUM_ENTRIES; gi++) begin : g_reg
        always_ff @(posedge clock) begin
            if (!rst_b) begin
                mem_q[gi] <= REG_RESET;
            end else if (ce) begin
                if (srst_q) begin
                    mem_q[gi] <= REG_RESET;
                end else if (wr_mem && wr_idx == 8'(gi)) begin
                    mem_q[gi] <= shift_q; // [RL15] [RL18]
                end
            end
        end
    end

    assign sda_o            = 1'b0;
    assign sda_oe           = sda_oe_q;
    assign active_page      = page_q;
    assign adc_rate_code    =
        mem_q[{PAGE0, REG_RATE}][RATE_MSB:RATE_LSB]; // [RL22]
    assign soft_reset_pulse = srst_q;
    assign bus_error_flag   = err_q;
    assign detector_on      = ~dbg_dis_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    idle_release_a: assert property ( // [RL1]
        (state_q == ST_IDLE || state_q == ST_WAIT) |-> !sda_oe)
        else $error("sda driven while not addressed");

    start_addr_a: assert property ( // [RL9]
        (ce && start_det) |=> (state_q == ST_ADDR && cnt_q == FIRST_BIT
                               && !sda_oe))
        else $error("start did not open an address phase");

    stop_idle_a: assert property ( // [RL9]
        (ce && stop_det) |=> (state_q == ST_IDLE && !sda_oe))
        else $error("stop did not idle the port");

    addr_ack_a: assert property ( // [RL6]
        (ce && state_q == ST_ADDR && full_q && scl_fall && !start_det
         && !stop_det && (addr_hit || gcall))
        |=> (sda_oe && state_q == ST_ADDR_ACK))
        else $error("own address not acknowledged");

    write_incr_a: assert property ( // [RL11]
        (ce && wr_fire) |=> (ptr_q == 7'($past(ptr_q) + PTR_STEP)))
        else $error("write pointer did not advance");

    read_incr_a: assert property ( // [RL12]
        (ce && rd_load && state_q == ST_RD_ACK)
        |=> (ptr_q == 7'($past(ptr_q) + PTR_STEP)
             && state_q == ST_RD_BYTE))
        else $error("read did not move to next register");

    page_sel_a: assert property ( // [RL19]
        (ce && wr_reg0 && !srst_q) |=> (page_q == $past(shift_q[PAGE_BIT])))
        else $error("page select not taken from D0");

    page_reset_a: assert property ( // [RL16]
        $rose(rst_b) |-> (page_q == PAGE0 && !dbg_dis_q))
        else $error("page not zero after reset");

    soft_reset_a: assert property ( // [RL20]
        (ce && wr_srst) |=> srst_q ##1 (!srst_q || !ce) ##0 (page_q == PAGE0))
        else $error("soft reset pulse wrong");

    error_gate_a: assert property ( // [RL13]
        $rose(err_q) |-> $past(!dbg_dis_q))
        else $error("bus error flagged while detector disabled");

endmodule

// ==== verification/i2cp_bus_master.sv ====
// Purpose: behavioural two-wire bus master that drives the control port
// Assumes: the system clock is the time base for every bus phase
// Notes:   phases are 12 clocks, safely above the port's 8-clock minimum
`timescale 1ns/1ps
module i2cp_bus_master (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0; // sda released, so the bus starts idle with both lines high
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // data moves only while scl is low, sampled mid-high
    task automatic put_bit(input logic b, output logic got);
        wait_clk(5);
        sda_pull = ~b;
        wait_clk(7);
        scl = 1'b1;
        wait_clk(6);
        got = sda_line;
        wait_clk(6);
        scl = 1'b0;
    endtask

    // sda falls while scl is high; also used as repeated start
    task automatic start_cond();
        wait_clk(5);
        sda_pull = 1'b0;
        wait_clk(7);
        scl = 1'b1;
        wait_clk(8);
        sda_pull = 1'b1;
        wait_clk(8);
        scl = 1'b0;
    endtask

    // sda rises while scl is high; both lines then stay high
    task automatic stop_cond();
        wait_clk(5);
        sda_pull = 1'b1;
        wait_clk(7);
        scl = 1'b1;
        wait_clk(8);
        sda_pull = 1'b0;
        wait_clk(8);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], g);
        end
        put_bit(1'b1, g);
        ack = ~g;
    endtask

    // ack pulls sda low in the ninth clock, nack leaves it high
    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(~mack, g);
    endtask

    // a cut-short byte, used to provoke the error detector
    task automatic send_bits(input int n);
        logic g;
        for (int i = 0; i < n; i++) begin
            put_bit(1'b1, g);
        end
    endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for the paged two-wire register port
// Assumes: master model drives scl and pulls sda; sda has a pull-up
// Notes:   expected values come from the package constants and the test's own data
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch at %0t: got %h want %h", $time, got, exp); \
        end \
    end
module testbench;
    import i2cp_pkg::*;

    logic       clock;
    logic       rst_b;
    logic [1:0] pins;
    logic       scl;
    logic       m_pull;
    wire logic  sda;
    logic       sda_o;
    logic       sda_oe;
    logic       active_page;
    logic [3:0] adc_rate_code;
    logic       soft_reset_pulse;
    logic       bus_error_flag;
    logic       detector_on;
    wire  [6:0] own;
    int         error_cnt;
    int         checked;
    int         pulse_cnt;
    int         cycles;
    logic       ack;
    logic [7:0] rd;
    logic [7:0] wbuf [4];

    // open drain: either party pulling wins, otherwise the pull-up
    assign sda = ~((sda_oe & ~sda_o) | m_pull);
    assign own = {ADDR_FIXED, pins};

    i2cp_slave_port u_i2cp_slave_port (
        .clock            (clock),
        .rst_b            (rst_b),
        .ce               (1'b1),
        .scl_i            (scl),
        .sda_i            (sda),
        .sda_o            (sda_o),
        .sda_oe           (sda_oe),
        .addr_select_pin0 (pins[0]),
        .addr_select_pin1 (pins[1]),
        .active_page      (active_page),
        .adc_rate_code    (adc_rate_code),
        .soft_reset_pulse (soft_reset_pulse),
        .bus_error_flag   (bus_error_flag),
        .detector_on      (detector_on)
    );

    i2cp_bus_master u_master (
        .clock    (clock),
        .sda_line (sda),
        .scl      (scl),
        .sda_pull (m_pull)
    );

    always #2.5 clock = ~clock;

    // about 16k cycles are needed; the ceiling leaves ample margin
    // the pulse is counted mid-cycle, away from the edge that launches it
    always @(negedge clock) begin
        if (soft_reset_pulse === 1'b1) begin
            pulse_cnt++;
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic open_dev(input logic rw);
        u_master.start_cond();
        u_master.send_byte({own, rw}, ack);
        `CHK(ack, 1'b1)
    endtask

    task automatic wr_regs(input logic [6:0] ptr, input int n);
        open_dev(1'b0);
        u_master.send_byte({1'b0, ptr}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            u_master.send_byte(wbuf[i], ack);
            `CHK(ack, 1'b1)
        end
        u_master.stop_cond();
    endtask

    // pointer write, repeated start, then n reads acked except the last
    task automatic rd_check(input logic [6:0] ptr, input int n);
        open_dev(1'b0);
        u_master.send_byte({1'b0, ptr}, ack);
        open_dev(1'b1);
        for (int i = 0; i < n; i++) begin
            u_master.recv_byte(i < n - 1, rd);
            `CHK(rd, wbuf[i])
        end
        u_master.stop_cond();
    endtask

    initial begin
        clock     = 1'b0;
        rst_b     = 1'b0;
        pins      = 2'h2;
        error_cnt = 0;
        checked   = 0;
        pulse_cnt = 0;
        cycles    = 0;
        repeat (5) @(posedge clock);
        #1;
        rst_b = 1'b1;
        u_master.wait_clk(6);
        `CHK(active_page, PAGE0)
        `CHK(adc_rate_code, 4'h0)
        `CHK(detector_on, 1'b1)
        `CHK(bus_error_flag, 1'b0)
        $display("test reset values done");
        for (int p = 0; p < 4; p++) begin
            pins = p[1:0];
            u_master.wait_clk(4);
            u_master.start_cond();
            u_master.send_byte({ADDR_FIXED, p[1:0], 1'b0}, ack);
            `CHK(ack, 1'b1)
            u_master.stop_cond();
        end
        u_master.start_cond();
        u_master.send_byte({ADDR_FIXED, 2'h0, 1'b0}, ack);
        `CHK(ack, 1'b0)
        `CHK(sda_oe, 1'b0)
        `CHK(sda_o, 1'b0)
        u_master.stop_cond();
        $display("test addressing done");
        // top legal rate code, then three more bytes in one burst
        wbuf = '{8'ha0, 8'h3c, 8'h5a, 8'hc3};
        wr_regs(REG_RATE, 4);
        `CHK(adc_rate_code, 4'ha)
        rd_check(REG_RATE, 4);
        `CHK(bus_error_flag, 1'b0)
        $display("test burst done");
        wbuf[0] = 8'h01;
        wr_regs(REG_PAGE, 1);
        rd_check(REG_PAGE, 1);
        `CHK(active_page, 1'b1)
        wbuf[0] = 8'h77;
        wr_regs(REG_RATE, 1);
        `CHK(adc_rate_code, 4'ha)
        rd_check(REG_RATE, 1);
        wbuf[0] = 8'h00;
        wr_regs(REG_PAGE, 1);
        `CHK(active_page, 1'b0)
        wbuf[0] = 8'ha0;
        rd_check(REG_RATE, 1);
        $display("test paging done");
        u_master.start_cond();
        u_master.send_byte(GEN_CALL, ack);
        `CHK(ack, 1'b1)
        u_master.send_byte(8'h20, ack);
        `CHK(ack, 1'b1)
        u_master.send_byte(8'h96, ack);
        `CHK(ack, 1'b1)
        u_master.stop_cond();
        wbuf[0] = 8'h96;
        rd_check(7'h20, 1);
        $display("test general call done");
        u_master.start_cond();
        u_master.send_bits(3);
        u_master.stop_cond();
        `CHK(bus_error_flag, 1'b1)
        wbuf[0] = 8'h01;
        rd_check(REG_DEBUG, 1);
        `CHK(bus_error_flag, 1'b0)
        wbuf[0] = 8'h04;
        wr_regs(REG_DEBUG, 1);
        `CHK(detector_on, 1'b0)
        u_master.start_cond();
        u_master.send_bits(3);
        u_master.stop_cond();
        `CHK(bus_error_flag, 1'b0)
        rd_check(REG_DEBUG, 1);
        $display("test error detector done");
        pulse_cnt = 0;
        wbuf[0] = 8'h80;
        wr_regs(REG_SRST, 1);
        `CHK(pulse_cnt, 1)
        `CHK(detector_on, 1'b1)
        `CHK(adc_rate_code, 4'h0)
        wbuf[0] = 8'h00;
        rd_check(REG_SRST, 1);
        wbuf[0] = 8'ha0;
        wr_regs(REG_RATE, 1);
        `CHK(adc_rate_code, 4'ha)
        $display("test soft reset done");
        conclude();
    end
endmodule
